// ===== logic/lrsc_defs.vh
// Purpose: Constants for the rail state control register bank.
// Assumes: Eight-bit register port with an eight-bit address.
// Notes: Field positions, offsets and reset values of the three rail registers.
`ifndef LRSC_DEFS_VH
`define LRSC_DEFS_VH
`define LRSC_ADDR_W 8
`define LRSC_DATA_W 8
`define LRSC_NUM_RAILS 3
`define LRSC_RAIL_HK 0
`define LRSC_RAIL_CORE 1
`define LRSC_RAIL_PANEL 2
`define LRSC_ADDR_HK 8'h41
`define LRSC_ADDR_CORE 8'h43
`define LRSC_ADDR_PANEL 8'h46
`define LRSC_RST_HK 8'h07
`define LRSC_RST_CORE 8'h3C
`define LRSC_RST_PANEL 8'h24
`define LRSC_RUN_MSB 2
`define LRSC_RUN_LSB 0
`define LRSC_EXIT_MSB 5
`define LRSC_EXIT_LSB 3
`define LRSC_FIELD_W 3
`define LRSC_VALID_BIT 2
`define LRSC_ST_OFF 3'h4
`define LRSC_ST_LOW 3'h5
`define LRSC_ZERO8 8'h00
`define LRSC_ZERO2 2'h0
`endif

// ===== logic/lrsc_ldo_rail_state_control.v
// Purpose: Control registers of three low-dropout rails sharing one input pin.
// Assumes: Register port and pins are synchronous to clk_sys_in.
// Notes: Read data is registered and appears one cycle after the read strobe.
// Notes: Rail status outputs are registered from the next run state, so they change
// on the same edge as the register write or standby-exit copy that causes them.
// Notes: Reserved run-state codes leave enable, low power and discharge all low.
// Notes: Event outputs are plain registered copies of the detector inputs.
`timescale 1ns/100ps
`include "lrsc_defs.vh"

module lrsc_ldo_rail_state_control (
  input wire clk_sys_in,
  input wire rst_in,
  input wire [`LRSC_ADDR_W-1:0] reg_addr_in,
  input wire [`LRSC_DATA_W-1:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire standby_exit_pin_in,
  input wire [`LRSC_NUM_RAILS-1:0] rail_overcurrent_in,
  input wire [`LRSC_NUM_RAILS-1:0] rail_undervoltage_in,
  output reg [`LRSC_DATA_W-1:0] reg_rdata_out,
  output reg reg_rvalid_out,
  output reg [`LRSC_NUM_RAILS-1:0] rail_enable_out,
  output reg [`LRSC_NUM_RAILS-1:0] rail_low_power_out,
  output reg [`LRSC_NUM_RAILS-1:0] rail_discharge_out,
  output reg [`LRSC_NUM_RAILS-1:0] rail_overcurrent_event_out,
  output reg [`LRSC_NUM_RAILS-1:0] rail_undervoltage_event_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and reset values per rail.
  function [`LRSC_NUM_RAILS-1:0] lrsc_decode;
    input [`LRSC_ADDR_W-1:0] addr;
    begin
      lrsc_decode = {`LRSC_NUM_RAILS{1'b0}};
      if (addr == `LRSC_ADDR_HK) begin
        lrsc_decode[`LRSC_RAIL_HK] = 1'b1;
      end else if (addr == `LRSC_ADDR_CORE) begin
        lrsc_decode[`LRSC_RAIL_CORE] = 1'b1;
      end else if (addr == `LRSC_ADDR_PANEL) begin
        lrsc_decode[`LRSC_RAIL_PANEL] = 1'b1;
      end
    end
  endfunction

  function [`LRSC_DATA_W-1:0] lrsc_reset_value;
    input integer idx;
    begin
      if (idx == `LRSC_RAIL_HK) begin
        lrsc_reset_value = `LRSC_RST_HK;
      end else if (idx == `LRSC_RAIL_CORE) begin
        lrsc_reset_value = `LRSC_RST_CORE;
      end else begin
        lrsc_reset_value = `LRSC_RST_PANEL;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field access and run-state decoding shared by all rails.
  function [`LRSC_FIELD_W-1:0] lrsc_run_field;
    input [`LRSC_DATA_W-1:0] word;
    begin
      lrsc_run_field = word[`LRSC_RUN_MSB:`LRSC_RUN_LSB];
    end
  endfunction

  function [`LRSC_FIELD_W-1:0] lrsc_exit_field;
    input [`LRSC_DATA_W-1:0] word;
    begin
      lrsc_exit_field = word[`LRSC_EXIT_MSB:`LRSC_EXIT_LSB];
    end
  endfunction

  function [`LRSC_DATA_W-1:0] lrsc_rail_word;
    input [`LRSC_FIELD_W-1:0] exit_field;
    input [`LRSC_FIELD_W-1:0] run_field;
    begin
      lrsc_rail_word = {`LRSC_ZERO2, exit_field, run_field};
    end
  endfunction

  function lrsc_state_on;
    input [`LRSC_FIELD_W-1:0] state;
    begin
      if (state[`LRSC_VALID_BIT] && (state != `LRSC_ST_OFF)) begin
        lrsc_state_on = 1'b1;
      end else begin
        lrsc_state_on = 1'b0;
      end
    end
  endfunction

  function lrsc_state_low;
    input [`LRSC_FIELD_W-1:0] state;
    begin
      if (state == `LRSC_ST_LOW) begin
        lrsc_state_low = 1'b1;
      end else begin
        lrsc_state_low = 1'b0;
      end
    end
  endfunction

  function lrsc_state_off;
    input [`LRSC_FIELD_W-1:0] state;
    begin
      if (state == `LRSC_ST_OFF) begin
        lrsc_state_off = 1'b1;
      end else begin
        lrsc_state_off = 1'b0;
      end
    end
  endfunction

  function lrsc_exit_copies;
    input [`LRSC_FIELD_W-1:0] exit_field;
    begin
      if (exit_field[`LRSC_VALID_BIT]) begin
        lrsc_exit_copies = 1'b1;
      end else begin
        lrsc_exit_copies = 1'b0;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register selects and next-value vectors.
  wire [`LRSC_NUM_RAILS-1:0] sel_wr;
  wire [`LRSC_NUM_RAILS-1:0] sel_rd;
  wire [`LRSC_DATA_W*`LRSC_NUM_RAILS-1:0] reg_flat;
  wire [`LRSC_NUM_RAILS-1:0] nxt_enable;
  wire [`LRSC_NUM_RAILS-1:0] nxt_low_power;
  wire [`LRSC_NUM_RAILS-1:0] nxt_discharge;
  reg [`LRSC_DATA_W-1:0] nxt_rdata;

  assign sel_wr = lrsc_decode(reg_addr_in);
  assign sel_rd = lrsc_decode(reg_addr_in);

  ////////////////////////////////////////////////////////////////////////////
  // One control register per rail.
  genvar g;
  generate
    for (g = 0; g < `LRSC_NUM_RAILS; g = g + 1) begin : rail
      reg [`LRSC_FIELD_W-1:0] run_ff;
      reg [`LRSC_FIELD_W-1:0] exit_ff;
      reg [`LRSC_FIELD_W-1:0] nxt_run;
      reg [`LRSC_FIELD_W-1:0] nxt_exit;
      wire [`LRSC_DATA_W-1:0] rst_val;
      wire [`LRSC_FIELD_W-1:0] rst_run;
      wire [`LRSC_FIELD_W-1:0] rst_exit;
      wire [`LRSC_FIELD_W-1:0] wr_run;
      wire [`LRSC_FIELD_W-1:0] wr_exit;
      wire wr_hit;
      wire exit_copy;

      assign rst_val = lrsc_reset_value(g);
      assign rst_run = lrsc_run_field(rst_val);
      assign rst_exit = lrsc_exit_field(rst_val);
      assign wr_run = lrsc_run_field(reg_wdata_in);
      assign wr_exit = lrsc_exit_field(reg_wdata_in);
      assign wr_hit = reg_wr_in && sel_wr[g];
      assign exit_copy = standby_exit_pin_in && lrsc_exit_copies(exit_ff);
      assign reg_flat[g*`LRSC_DATA_W +: `LRSC_DATA_W] =
        lrsc_rail_word(exit_ff, run_ff);
      assign nxt_enable[g] = lrsc_state_on(nxt_run);
      assign nxt_low_power[g] = lrsc_state_low(nxt_run);
      assign nxt_discharge[g] = lrsc_state_off(nxt_run);

      // The exit field changes only on a write to this rail.
      always @* begin
        nxt_exit = exit_ff;
        if (wr_hit) begin
          nxt_exit = wr_exit;
        end
      end

      // The run state takes a write, and a standby-exit copy overrides it.
      always @* begin
        nxt_run = run_ff;
        if (wr_hit) begin
          nxt_run = wr_run;
        end
        if (exit_copy) begin
          nxt_run = exit_ff;
        end
      end

      always @(posedge clk_sys_in) begin
        if (rst_in) begin
          run_ff <= rst_run;
          exit_ff <= rst_exit;
        end else begin
          run_ff <= nxt_run;
          exit_ff <= nxt_exit;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Rail enable outputs follow the next run state.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rail_enable_out <= {`LRSC_NUM_RAILS{1'b0}};
    end else begin
      rail_enable_out <= nxt_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail low-power outputs follow the next run state.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rail_low_power_out <= {`LRSC_NUM_RAILS{1'b0}};
    end else begin
      rail_low_power_out <= nxt_low_power;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail discharge outputs are high while a rail is off.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rail_discharge_out <= {`LRSC_NUM_RAILS{1'b0}};
    end else begin
      rail_discharge_out <= nxt_discharge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Over-current events mirror the detectors one cycle late.
  // They are levels, so software sees the condition only while it lasts.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rail_overcurrent_event_out <= {`LRSC_NUM_RAILS{1'b0}};
    end else begin
      rail_overcurrent_event_out <= rail_overcurrent_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Under-voltage events mirror the detectors one cycle late.
  // They are levels, so software sees the condition only while it lasts.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rail_undervoltage_event_out <= {`LRSC_NUM_RAILS{1'b0}};
    end else begin
      rail_undervoltage_event_out <= rail_undervoltage_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read valid is a one-cycle pulse after each read strobe.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped addresses and idle cycles read as zero.
  always @* begin
    nxt_rdata = `LRSC_ZERO8;
    if (!reg_rd_in) begin
      nxt_rdata = `LRSC_ZERO8;
    end else if (sel_rd[`LRSC_RAIL_HK]) begin
      nxt_rdata = reg_flat[`LRSC_RAIL_HK*`LRSC_DATA_W +: `LRSC_DATA_W];
    end else if (sel_rd[`LRSC_RAIL_CORE]) begin
      nxt_rdata = reg_flat[`LRSC_RAIL_CORE*`LRSC_DATA_W +: `LRSC_DATA_W];
    end else if (sel_rd[`LRSC_RAIL_PANEL]) begin
      nxt_rdata = reg_flat[`LRSC_RAIL_PANEL*`LRSC_DATA_W +: `LRSC_DATA_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read data.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= `LRSC_ZERO8;
    end else begin
      reg_rdata_out <= nxt_rdata;
    end
  end

endmodule

// ===== bench/lrsc_host_model.sv
// Purpose: Host register access model. Assumes: Falling-edge drive. Notes: Reads await rvalid.
`timescale 1ns/100ps
module lrsc_host_model (
  input wire clk_sys_in,
  input wire [7:0] rdata_in,
  input wire rvalid_in,
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0
);
  logic [7:0] got;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
    @(negedge clk_sys_in);
    {wr_out, rd_out, addr_out, wdata_out} = {2'h0, ~a, ~d};
    got = 8'hEE;
    repeat (3) begin
      if (rvalid_in === 1'b1) got = rdata_in;
      @(negedge clk_sys_in);
    end
  endtask
endmodule

// ===== bench/lrsc_ldo_props.sv
// Purpose: Port checker. Assumes: One clock. Notes: Bound by name.
`timescale 1ns/100ps
module lrsc_ldo_props (
  input wire clk_sys_in, rst_in, reg_rd_in, reg_wr_in, standby_exit_pin_in, reg_rvalid_out,
  input wire [7:0] reg_addr_in, reg_rdata_out,
  input wire [2:0] rail_overcurrent_in, rail_undervoltage_in, rail_enable_out,
  input wire [2:0] rail_low_power_out, rail_discharge_out,
  input wire [2:0] rail_overcurrent_event_out, rail_undervoltage_event_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  on_or_off_a: assert property (!$past(rst_in) |->
    (rail_enable_out ^ rail_discharge_out) == 3'h7) else $error("rail state");
  low_power_a: assert property ((rail_low_power_out & ~rail_enable_out) == 3'h0)
    else $error("low power");
  read_valid_a: assert property (!$past(rst_in) |-> reg_rvalid_out == $past(reg_rd_in))
    else $error("rvalid");
  rsvd_zero_a: assert property (reg_rdata_out[7:6] == 2'h0) else $error("rsvd");
  unmap_read_a: assert property (reg_rd_in && !(reg_addr_in inside {8'h41, 8'h43, 8'h46})
    |=> reg_rdata_out == 8'h00) else $error("unmapped");
  oc_event_a: assert property (!$past(rst_in) |->
    rail_overcurrent_event_out == $past(rail_overcurrent_in)) else $error("oc");
  uv_event_a: assert property (!$past(rst_in) |->
    rail_undervoltage_event_out == $past(rail_undervoltage_in)) else $error("uv");
  rail_iso_a: assert property (reg_wr_in && reg_addr_in == 8'h43 && !standby_exit_pin_in
    |=> $stable(rail_enable_out[0]) && $stable(rail_enable_out[2])) else $error("iso");
  cover property (reg_rvalid_out);
  cover property (standby_exit_pin_in);
  cover property (|rail_low_power_out);
endmodule
bind lrsc_ldo_rail_state_control lrsc_ldo_props lrsc_ldo_props_i (.*);

// ===== bench/testbench.sv
// Purpose: Self-checking bench. Assumes: 125 MHz clock. Notes: Fixed seed.
`timescale 1ns/100ps
module testbench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic standby_exit_pin_in = 1'b0;
  logic [2:0] rail_overcurrent_in = 3'h0;
  logic [2:0] rail_undervoltage_in = 3'h0;
  wire [2:0] rail_enable_out, rail_low_power_out, rail_discharge_out;
  wire [2:0] rail_overcurrent_event_out, rail_undervoltage_event_out;
  wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic [7:0] m [3];
  logic [7:0] adr [3] = '{8'h41, 8'h43, 8'h46};
  logic [7:0] d;
  int k;
  int err_total = 0;
  int total_checks = 0;
  logic [5:0] ev_exp = 6'h00;
  always @(posedge clk_sys_in) ev_exp <= {rail_overcurrent_in, rail_undervoltage_in};
  initial forever #4 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) {rail_overcurrent_in, rail_undervoltage_in} <= 6'($urandom);
  lrsc_ldo_rail_state_control lrsc_ldo_rail_state_control_i (.*);
  lrsc_host_model lrsc_host_model_i (.clk_sys_in(clk_sys_in), .rdata_in(reg_rdata_out),
    .rvalid_in(reg_rvalid_out), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in),
    .wr_out(reg_wr_in), .rd_out(reg_rd_in));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_all;
    for (int r = 0; r < 3; r++) begin
      lrsc_host_model_i.acc(1'b0, adr[r], 8'h00);
      chk(lrsc_host_model_i.got, m[r]);
      chk({rail_enable_out[r], rail_low_power_out[r], rail_discharge_out[r]},
        {5'h0, m[r][2:0] >= 3'h5, m[r][2:0] == 3'h5, m[r][2:0] == 3'h4});
    end
    chk({2'h0, rail_overcurrent_event_out, rail_undervoltage_event_out}, {2'h0, ev_exp});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  initial begin
    void'($urandom(22382));
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
    m = '{8'h07, 8'h3C, 8'h24};
    chk_all();
    lrsc_host_model_i.acc(1'b0, 8'h42, 8'h00);
    chk(lrsc_host_model_i.got, 8'h00);
    $display("test reset done");
    for (int n = 0; n < 40; n++) begin
      k = $urandom_range(2);
      d = 8'($urandom) | 8'h04;
      if (n < 4) d = {2'h3, 3'(n), 3'h4 + 3'(n)};
      lrsc_host_model_i.acc(1'b1, adr[k], d);
      m[k] = d & 8'h3F;
      chk_all();
    end
    $display("test writes done");
    for (int n = 0; n < 8; n++) begin
      for (int r = 0; r < 3; r++) begin
        m[r] = {2'h0, 3'($urandom), m[r][2:0]};
        lrsc_host_model_i.acc(1'b1, adr[r], m[r]);
      end
      @(negedge clk_sys_in) standby_exit_pin_in = 1'b1;
      @(negedge clk_sys_in) standby_exit_pin_in = 1'b0;
      for (int r = 0; r < 3; r++) if (m[r][5]) m[r][2:0] = m[r][5:3];
      chk_all();
    end
    $display("test standby done");
    finish_test();
  end
endmodule
